// ==== hdl/iep_pkg.sv ====
// shared constants for the interrupt enable, priority and edge flag block
package iep_pkg;

    // ------------------------------------------------------------
    // source and group counts
    // ------------------------------------------------------------
    localparam int NUM_SRC = 24;
    localparam int NUM_GRP = 6;
    localparam int NUM_KEY = 8;
    localparam int NUM_EXT = 2;
    localparam int NUM_EVT = 4;

    // ------------------------------------------------------------
    // register indices; byte address is four times the index
    // ------------------------------------------------------------
    localparam logic [7:0] IDX_EXT_FLAG = 8'ha4;
    localparam logic [7:0] IDX_EXT_POL = 8'ha5;
    localparam logic [7:0] IDX_MAIN_EN = 8'ha8;
    localparam logic [7:0] IDX_SER_EN = 8'ha9;
    localparam logic [7:0] IDX_TMR_EN = 8'haa;
    localparam logic [7:0] IDX_SYS_EN = 8'hab;
    localparam logic [7:0] IDX_KPOL_LO = 8'hae;
    localparam logic [7:0] IDX_KPOL_HI = 8'haf;
    localparam logic [7:0] IDX_PRIO_LO = 8'hb8;
    localparam logic [7:0] IDX_KEY_FLAG = 8'he8;
    localparam logic [7:0] IDX_PRIO_HI = 8'hf8;
    localparam logic [7:0] IDX_EVT_STAT = 8'hc0;
    localparam logic [7:0] IDX_EVT_CLR = 8'hc1;
    localparam logic [7:0] IDX_EVT_EN = 8'hc2;
    localparam logic [7:0] IDX_IN_SVC = 8'hc3;

    // ------------------------------------------------------------
    // writable bit masks and reset value
    // ------------------------------------------------------------
    localparam logic [7:0] MASK_MAIN_EN = 8'ha6;
    localparam logic [7:0] MASK_SER_EN = 8'h20;
    localparam logic [7:0] MASK_TMR_EN = 8'h1e;
    localparam logic [7:0] MASK_SYS_EN = 8'h1c;
    localparam logic [7:0] MASK_PRIO = 8'h3f;
    localparam logic [7:0] MASK_EXT = 8'h03;
    localparam logic [7:0] MASK_EXT_POL = 8'h0f;
    localparam logic [7:0] MASK_EVT = 8'h0f;
    localparam logic [7:0] REG_RESET = 8'h00;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int POS_GLOBAL_EN = 7;
    localparam int POS_KEY_EN = 5;
    localparam int POS_PIN2_EN = 2;
    localparam int POS_PIN1_EN = 1;
    localparam int POS_SER_EN = 5;
    localparam int SRC_PIN1 = 1;
    localparam int SRC_PIN2 = 2;
    localparam int SRC_KEY = 5;
    localparam int SRC_SER = 11;
    localparam int SRC_TMR0 = 13;
    localparam int SRC_WATCH = 20;
    localparam int EVT_PIN1 = 0;
    localparam int EVT_PIN2 = 1;
    localparam int EVT_KEY = 2;
    localparam int EVT_TAKEN = 3;

    typedef enum logic [1:0] {
        IEP_EDGE_NONE = 2'b00,
        IEP_EDGE_RISE = 2'b01,
        IEP_EDGE_FALL = 2'b10,
        IEP_EDGE_BOTH = 2'b11
    } iep_edge_e;

endpackage : iep_pkg

// ==== hdl/iep_edge_detect.sv ====
// pin synchroniser and selectable edge detector
`timescale 1ns/1ps
module iep_edge_detect
    import iep_pkg::*;
#(
    parameter int N = 10
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [N-1:0] pin_i,
    input wire logic [2*N-1:0] sel_i,
    output logic [N-1:0] edge_o
);

    logic [N-1:0] meta_q;
    logic [N-1:0] sync_q;
    logic [N-1:0] prev_q;
    logic [N-1:0] edge_d;

    // only sync_q reads meta_q
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            meta_q <= '0;
            sync_q <= '0;
            prev_q <= '0;
        end else begin
            meta_q <= pin_i;
            sync_q <= meta_q;
            prev_q <= sync_q;
        end
    end

    always_comb begin
        for (int i = 0; i < N; i++) begin
            unique case (iep_edge_e'(sel_i[2*i +: 2]))
                IEP_EDGE_NONE: edge_d[i] = 1'b0;
                IEP_EDGE_RISE: edge_d[i] = sync_q[i] & ~prev_q[i];
                IEP_EDGE_FALL: edge_d[i] = ~sync_q[i] & prev_q[i];
                IEP_EDGE_BOTH: edge_d[i] = sync_q[i] ^ prev_q[i];
            endcase
        end
    end

    // one pulse per qualifying transition
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            edge_o <= '0;
        end else begin
            edge_o <= edge_d;
        end
    end

endmodule : iep_edge_detect

// ==== hdl/iep_ctrl.sv ====
// interrupt enables, group priority, pin and key edge flags, arbitration
`timescale 1ns/1ps
module iep_ctrl
    import iep_pkg::*;
#(
    parameter int ADR_W = 10
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [ADR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic [1:0] ext_pin_i,
    input wire logic [7:0] key_pin_i,
    input wire logic [NUM_SRC-1:0] periph_req_i,
    input wire logic int_ack_i,
    input wire logic reti_i,
    output logic irq_req_o,
    output logic [4:0] irq_vec_o,
    output logic [1:0] irq_lvl_o,
    output logic [NUM_SRC-1:0] ack_src_o,
    output logic evt_irq_o
);

    // ------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------
    logic [7:0] main_en_q;
    logic [7:0] ser_en_q;
    logic [7:0] tmr_en_q;
    logic [7:0] sys_en_q;
    logic [7:0] prio_lo_q;
    logic [7:0] prio_hi_q;
    logic [7:0] ext_pol_q;
    logic [7:0] kpol_lo_q;
    logic [7:0] kpol_hi_q;
    logic [1:0] ext_flag_q;
    logic [1:0] ext_flag_d;
    logic [7:0] key_flag_q;
    logic [7:0] key_flag_d;
    logic [3:0] evt_stat_q;
    logic [3:0] evt_en_q;
    logic [3:0] in_svc_q;
    logic [9:0] pin_edge;
    logic [1:0] ext_evt;
    logic [7:0] key_evt;
    logic [3:0] evt_set;
    logic [7:0] idx;
    logic [7:0] wdat;
    logic [7:0] rd_d;
    logic acc;
    logic wr;
    logic take;
    logic key_wr;
    logic [NUM_SRC-1:0] src_pend;
    logic [NUM_SRC-1:0] src_en;
    logic [NUM_SRC-1:0] src_req;
    logic best_ok;
    logic [1:0] best_lvl;
    logic [4:0] best_idx;
    logic act_any;
    logic [1:0] act_lvl;
    logic irq_req_d;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [1:0] grp_lvl(input logic [7:0] lo, input logic [7:0] hi,
                                           input int src);
        int g;
        g = src / 4;
        return {hi[g], lo[g]};
    endfunction : grp_lvl

    function automatic logic [7:0] wr_mask(input logic [7:0] old, input logic [7:0] val,
                                           input logic [7:0] mask);
        return (old & ~mask) | (val & mask);
    endfunction : wr_mask

    // ------------------------------------------------------------
    // wishbone slave: ack one cycle after request, write at ack edge
    // ------------------------------------------------------------
    assign idx = wb_adr_i[9:2];
    assign wdat = wb_dat_i[7:0];
    assign acc = wb_cyc_i & wb_stb_i;
    assign wr = acc & wb_we_i & wb_ack_o & wb_sel_i[0];
    assign key_wr = wr & (idx == IDX_KEY_FLAG);
    assign take = int_ack_i & irq_req_o;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= '0;
        end else begin
            wb_ack_o <= acc & ~wb_ack_o;
            wb_dat_o <= {24'h0, rd_d};
        end
    end

    // unmapped indices answer with zero
    always_comb begin
        unique case (idx)
            IDX_EXT_FLAG: rd_d = {6'h0, ext_flag_q};
            IDX_EXT_POL: rd_d = ext_pol_q;
            IDX_MAIN_EN: rd_d = main_en_q;
            IDX_SER_EN: rd_d = ser_en_q;
            IDX_TMR_EN: rd_d = tmr_en_q;
            IDX_SYS_EN: rd_d = sys_en_q;
            IDX_KPOL_LO: rd_d = kpol_lo_q;
            IDX_KPOL_HI: rd_d = kpol_hi_q;
            IDX_PRIO_LO: rd_d = prio_lo_q;
            IDX_KEY_FLAG: rd_d = key_flag_q;
            IDX_PRIO_HI: rd_d = prio_hi_q;
            IDX_EVT_STAT: rd_d = {4'h0, evt_stat_q};
            IDX_EVT_EN: rd_d = {4'h0, evt_en_q};
            IDX_IN_SVC: rd_d = {4'h0, in_svc_q};
            default: rd_d = 8'h00;
        endcase
    end

    // ------------------------------------------------------------
    // control registers
    // ------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            main_en_q <= REG_RESET;
            ser_en_q <= REG_RESET;
            tmr_en_q <= REG_RESET;
            sys_en_q <= REG_RESET;
            prio_lo_q <= REG_RESET;
            prio_hi_q <= REG_RESET;
            ext_pol_q <= REG_RESET;
            kpol_lo_q <= REG_RESET;
            kpol_hi_q <= REG_RESET;
            evt_en_q <= '0;
        end else if (wr) begin
            unique case (idx)
                IDX_MAIN_EN: main_en_q <= wr_mask(main_en_q, wdat, MASK_MAIN_EN);
                IDX_SER_EN: ser_en_q <= wr_mask(ser_en_q, wdat, MASK_SER_EN);
                IDX_TMR_EN: tmr_en_q <= wr_mask(tmr_en_q, wdat, MASK_TMR_EN);
                IDX_SYS_EN: sys_en_q <= wr_mask(sys_en_q, wdat, MASK_SYS_EN);
                IDX_PRIO_LO: prio_lo_q <= wr_mask(prio_lo_q, wdat, MASK_PRIO);
                IDX_PRIO_HI: prio_hi_q <= wr_mask(prio_hi_q, wdat, MASK_PRIO);
                IDX_EXT_POL: ext_pol_q <= wr_mask(ext_pol_q, wdat, MASK_EXT_POL);
                IDX_KPOL_LO: kpol_lo_q <= wdat;
                IDX_KPOL_HI: kpol_hi_q <= wdat;
                IDX_EVT_EN: evt_en_q <= wdat[3:0];
                default: ;
            endcase
        end
    end

    // ------------------------------------------------------------
    // edge detection on pins and key lines
    // ------------------------------------------------------------
    // lines 0-3 from the lower register, 4-7 from the upper
    iep_edge_detect #(
        .N(NUM_EXT + NUM_KEY)
    ) u_edges (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .pin_i({key_pin_i, ext_pin_i}),
        .sel_i({kpol_hi_q, kpol_lo_q, ext_pol_q[3:0]}),
        .edge_o(pin_edge)
    );

    assign ext_evt = pin_edge[1:0];
    assign key_evt = pin_edge[9:2];

    // ------------------------------------------------------------
    // pending flags; a new edge beats a clear in the same cycle
    // ------------------------------------------------------------
    always_comb begin
        ext_flag_d = ext_flag_q;
        if (wr && idx == IDX_EXT_FLAG) begin
            ext_flag_d = ext_flag_d & wdat[1:0];
        end
        if (take && irq_vec_o == 5'(SRC_PIN1)) begin
            ext_flag_d[0] = 1'b0;
        end
        if (take && irq_vec_o == 5'(SRC_PIN2)) begin
            ext_flag_d[1] = 1'b0;
        end
        ext_flag_d = ext_flag_d | ext_evt;
    end

    // acknowledge never touches the key flags
    always_comb begin
        key_flag_d = key_flag_q;
        if (key_wr) begin
            key_flag_d = key_flag_d & wdat;
        end
        key_flag_d = key_flag_d | key_evt;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ext_flag_q <= '0;
            key_flag_q <= '0;
        end else begin
            ext_flag_q <= ext_flag_d;
            key_flag_q <= key_flag_d;
        end
    end

    // ------------------------------------------------------------
    // source gating
    // ------------------------------------------------------------
    always_comb begin
        src_pend = periph_req_i;
        src_pend[SRC_PIN1] = ext_flag_q[0];
        src_pend[SRC_PIN2] = ext_flag_q[1];
        src_pend[SRC_KEY] = |key_flag_q;
        src_en = '0;
        src_en[SRC_PIN1] = main_en_q[POS_PIN1_EN];
        src_en[SRC_PIN2] = main_en_q[POS_PIN2_EN];
        src_en[SRC_KEY] = main_en_q[POS_KEY_EN];
        src_en[SRC_SER] = ser_en_q[POS_SER_EN];
        src_en[SRC_TMR0 +: 4] = tmr_en_q[4:1];
        src_en[SRC_WATCH +: 3] = sys_en_q[4:2];
        src_req = src_pend & src_en & {NUM_SRC{main_en_q[POS_GLOBAL_EN]}};
    end

    // ------------------------------------------------------------
    // arbitration and preemption
    // ------------------------------------------------------------
    // strict compare keeps the lowest number among equal levels
    always_comb begin
        best_ok = 1'b0;
        best_lvl = 2'd0;
        best_idx = 5'd0;
        for (int i = 0; i < NUM_SRC; i++) begin
            if (src_req[i] && (!best_ok || grp_lvl(prio_lo_q, prio_hi_q, i) > best_lvl)) begin
                best_ok = 1'b1;
                best_lvl = grp_lvl(prio_lo_q, prio_hi_q, i);
                best_idx = 5'(i);
            end
        end
    end

    always_comb begin
        act_any = |in_svc_q;
        act_lvl = 2'd0;
        for (int l = 0; l < 4; l++) begin
            if (in_svc_q[l]) begin
                act_lvl = 2'(l);
            end
        end
        irq_req_d = best_ok && (!act_any || best_lvl > act_lvl);
    end

    // request drops the cycle after acceptance
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_req_o <= 1'b0;
            irq_vec_o <= '0;
            irq_lvl_o <= '0;
        end else begin
            irq_req_o <= irq_req_d & ~take;
            irq_vec_o <= best_idx;
            irq_lvl_o <= best_lvl;
        end
    end

    // one in-service bit per level; return retires the highest
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            in_svc_q <= '0;
            ack_src_o <= '0;
        end else begin
            ack_src_o <= '0;
            if (reti_i && act_any) begin
                in_svc_q[act_lvl] <= 1'b0;
            end
            if (take) begin
                in_svc_q[irq_lvl_o] <= 1'b1;
                ack_src_o[irq_vec_o] <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // event status, clear and enable, interrupt line
    // ------------------------------------------------------------
    assign evt_set = {take, |key_evt, ext_evt};

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            evt_stat_q <= '0;
        end else if (wr && idx == IDX_EVT_CLR) begin
            evt_stat_q <= (evt_stat_q & ~wdat[3:0]) | evt_set;
        end else begin
            evt_stat_q <= evt_stat_q | evt_set;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            evt_irq_o <= 1'b0;
        end else begin
            evt_irq_o <= |(evt_stat_q & evt_en_q);
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    property p_tmr0_gate;
        @(posedge clk_i) disable iff (rst_i)
        (irq_req_o && irq_vec_o == 5'd13) |-> $past(tmr_en_q[1]);
    endproperty
    a_tmr0_gate: assert property (p_tmr0_gate) else $error("timer0 req while off");

    property p_bit_gate;
        @(posedge clk_i) disable iff (rst_i)
        (irq_req_o && irq_vec_o == 5'd22) |-> $past(sys_en_q[4]);
    endproperty
    a_bit_gate: assert property (p_bit_gate) else $error("interval req while off");

    property p_pin_set;
        @(posedge clk_i) disable iff (rst_i)
        ext_evt[0] |=> ext_flag_q[0];
    endproperty
    a_pin_set: assert property (p_pin_set) else $error("pin edge lost");

    property p_pin_ack;
        @(posedge clk_i) disable iff (rst_i)
        (take && irq_vec_o == 5'd1 && !ext_evt[0]) |=> !ext_flag_q[0];
    endproperty
    a_pin_ack: assert property (p_pin_ack) else $error("pin flag kept on ack");

    property p_pol_none;
        @(posedge clk_i) disable iff (rst_i)
        $rose(ext_flag_q[0]) |-> $past(ext_pol_q[1:0], 2) != 2'b00;
    endproperty
    a_pol_none: assert property (p_pol_none) else $error("edge with code none");

    property p_key_hold;
        @(posedge clk_i) disable iff (rst_i)
        !$past(key_wr) |-> ((key_flag_q & $past(key_flag_q)) == $past(key_flag_q));
    endproperty
    a_key_hold: assert property (p_key_hold) else $error("key flag dropped");

    property p_global;
        @(posedge clk_i) disable iff (rst_i)
        irq_req_o |-> $past(main_en_q[7]);
    endproperty
    a_global: assert property (p_global) else $error("req with global off");

    property p_preempt;
        @(posedge clk_i) disable iff (rst_i)
        irq_req_o |-> (!$past(act_any) || irq_lvl_o > $past(act_lvl));
    endproperty
    a_preempt: assert property (p_preempt) else $error("preempt at equal level");

    property p_reserved;
        @(posedge clk_i) disable iff (rst_i)
        (acc && !wb_we_i && !wb_ack_o && idx == IDX_TMR_EN) |=>
            (wb_dat_o[7:5] == 3'b000 && wb_dat_o[0] == 1'b0);
    endproperty
    a_reserved: assert property (p_reserved) else $error("reserved bit reads one");

endmodule : iep_ctrl

// ==== bench/iep_cpu_model.sv ====
// behavioural cpu core that accepts and returns interrupts
`timescale 1ns/1ps
module iep_cpu_model (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic irq_req_i,
    input wire logic go_i,
    input wire logic [3:0] delay_i,
    input wire logic ret_i,
    output logic int_ack_o,
    output logic reti_o
);
    logic [3:0] wait_q;

    // ----------------------------------------
    // acceptance after a chosen number of cycles
    // ----------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wait_q <= 4'h0;
            int_ack_o <= 1'b0;
        end else begin
            int_ack_o <= 1'b0;
            // never two accepts in a row: request needs a cycle to fall
            if (!go_i || !irq_req_i || int_ack_o) begin
                wait_q <= 4'h0;
            end else if (wait_q >= delay_i) begin
                int_ack_o <= 1'b1;
                wait_q <= 4'h0;
            end else begin
                wait_q <= wait_q + 4'h1;
            end
        end
    end

    // ----------------------------------------
    // return, only when the bench closes a routine
    // ----------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            reti_o <= 1'b0;
        end else begin
            reti_o <= ret_i;
        end
    end
endmodule : iep_cpu_model

// ==== bench/iep_ctrl_tb_top.sv ====
// self-checking bench for the interrupt enable, priority and edge flag block
`timescale 1ns/1ps
module iep_ctrl_tb_top;
    import iep_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic wb_cyc = 1'b0;
    logic wb_stb = 1'b0;
    logic wb_we = 1'b0;
    logic [9:0] wb_adr = 10'h000;
    logic [31:0] wb_dat = 32'h0;
    logic [31:0] wb_dat_o;
    logic wb_ack_o;
    logic [1:0] ext = 2'b00;
    logic [7:0] key = 8'h00;
    logic [23:0] per_req = 24'h0;
    logic [23:0] per_set = 24'h0;
    logic cpu_go = 1'b0;
    logic ret = 1'b0;
    logic int_ack;
    logic reti;
    logic irq_req_o;
    logic [4:0] irq_vec_o;
    logic [1:0] irq_lvl_o;
    logic [23:0] ack_src_o;
    logic evt_irq_o;
    logic [23:0] last_ack = 24'h0;
    int err_total = 0;
    int n_compared = 0;
    logic [7:0] idx_tab [12] = '{IDX_EXT_FLAG, IDX_EXT_POL, IDX_MAIN_EN, IDX_SER_EN, IDX_TMR_EN,
        IDX_SYS_EN, IDX_KPOL_LO, IDX_KPOL_HI, IDX_PRIO_LO, IDX_KEY_FLAG, IDX_PRIO_HI, 8'h10};
    logic [7:0] msk_tab [12] = '{8'h00, 8'h0f, 8'ha6, 8'h20, 8'h1e, 8'h1c, 8'hff, 8'hff,
        8'h3f, 8'h00, 8'h3f, 8'h00};

    always #5 clk = ~clk;

    iep_ctrl dut_u (.clk_i(clk), .rst_i(rst), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
        .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(4'h1), .wb_dat_i(wb_dat),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .ext_pin_i(ext), .key_pin_i(key),
        .periph_req_i(per_req), .int_ack_i(int_ack), .reti_i(reti), .irq_req_o(irq_req_o),
        .irq_vec_o(irq_vec_o), .irq_lvl_o(irq_lvl_o), .ack_src_o(ack_src_o),
        .evt_irq_o(evt_irq_o));

    iep_cpu_model cpu_u (.clk_i(clk), .rst_i(rst), .irq_req_i(irq_req_o), .go_i(cpu_go),
        .delay_i(4'h2), .ret_i(ret), .int_ack_o(int_ack), .reti_o(reti));

    // ----------------------------------------
    // peripheral requests hold until acknowledged
    // ----------------------------------------
    always @(posedge clk) begin
        per_req <= rst ? 24'h0 : (per_req | per_set) & ~ack_src_o;
        if (ack_src_o != 24'h0) last_ack <= ack_src_o;
    end

    // ----------------------------------------
    // bus and compare helpers
    // ----------------------------------------
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            $display("BAD %s exp %h got %h", what, exp, got);
            err_total++;
        end
    endtask : chk

    task automatic wb_xfer(input logic we, input logic [7:0] idx, input logic [7:0] wd,
            output logic [31:0] rd);
        int n;
        @(posedge clk);
        n = 0;
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we <= we;
        wb_adr <= {idx, 2'b00};
        wb_dat <= {24'h0, wd};
        do begin
            @(posedge clk);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 16);
        if (n >= 16) chk("wb_ack", 32'h1, 32'h0);
        rd = wb_dat_o;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        wb_we <= 1'b0;
    endtask : wb_xfer

    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        logic [31:0] v;
        wb_xfer(1'b1, idx, d, v);
    endtask : wr

    task automatic rd_chk(input string what, input logic [7:0] idx, input logic [7:0] exp);
        logic [31:0] v;
        wb_xfer(1'b0, idx, 8'h00, v);
        chk(what, {24'h0, exp}, v);
    endtask : rd_chk

    task automatic wait_cyc(input int n);
        repeat (n) @(posedge clk);
    endtask : wait_cyc

    task automatic ret_pulse();
        ret <= 1'b1;
        @(posedge clk);
        ret <= 1'b0;
    endtask : ret_pulse

    task automatic stop_test();
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : stop_test

    // ----------------------------------------
    // tests
    // ----------------------------------------
    initial begin
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        foreach (idx_tab[i]) rd_chk("reset", idx_tab[i], 8'h00);
        foreach (idx_tab[i]) begin
            wr(idx_tab[i], 8'hff);
            rd_chk("mask", idx_tab[i], msk_tab[i]);
            wr(idx_tab[i], 8'h00);
        end
        $display("test registers done");
        for (int c = 0; c < 4; c++) begin
            wr(IDX_EXT_POL, {4'h0, c[1:0], c[1:0]});
            ext <= 2'b11;
            wait_cyc(8);
            rd_chk("ext_rise", IDX_EXT_FLAG, {6'h0, {2{c[0]}}});
            wr(IDX_EXT_FLAG, 8'h00);
            ext <= 2'b00;
            wait_cyc(8);
            rd_chk("ext_fall", IDX_EXT_FLAG, {6'h0, {2{c[1]}}});
            wr(IDX_EXT_FLAG, 8'h03);
            rd_chk("ext_keep", IDX_EXT_FLAG, {6'h0, {2{c[1]}}});
            wr(IDX_EXT_FLAG, 8'h00);
        end
        $display("test pins done");
        rd_chk("evt_stat", IDX_EVT_STAT, 8'h03);
        chk("evt_irq", 32'h0, {31'h0, evt_irq_o});
        wr(IDX_EVT_EN, 8'h02);
        wait_cyc(2);
        chk("evt_irq", 32'h1, {31'h0, evt_irq_o});
        wr(IDX_EVT_CLR, 8'h02);
        wait_cyc(2);
        chk("evt_irq", 32'h0, {31'h0, evt_irq_o});
        rd_chk("evt_stat", IDX_EVT_STAT, 8'h01);
        $display("test events done");
        wr(IDX_KPOL_LO, 8'h55);
        wr(IDX_KPOL_HI, 8'haa);
        key <= 8'hff;
        wait_cyc(8);
        rd_chk("key_rise", IDX_KEY_FLAG, 8'h0f);
        key <= 8'h00;
        wait_cyc(8);
        rd_chk("key_fall", IDX_KEY_FLAG, 8'hff);
        wr(IDX_KEY_FLAG, 8'hf0);
        rd_chk("key_clr", IDX_KEY_FLAG, 8'hf0);
        $display("test keys done");
        wr(IDX_EXT_POL, 8'h01);
        wr(IDX_MAIN_EN, 8'h22);
        ext <= 2'b01;
        wait_cyc(8);
        chk("irq_off", 32'h0, {31'h0, irq_req_o});
        wr(IDX_MAIN_EN, 8'h82);
        wait_cyc(2);
        chk("vec_pin", 32'h1, {27'h0, irq_vec_o});
        cpu_go <= 1'b1;
        wait_cyc(6);
        cpu_go <= 1'b0;
        chk("ack_pin", 32'h2, {8'h0, last_ack});
        rd_chk("ext_ack", IDX_EXT_FLAG, 8'h00);
        ret_pulse();
        wr(IDX_MAIN_EN, 8'ha0);
        wait_cyc(2);
        chk("vec_key", 32'h5, {27'h0, irq_vec_o});
        cpu_go <= 1'b1;
        wait_cyc(6);
        cpu_go <= 1'b0;
        chk("ack_key", 32'h20, {8'h0, last_ack});
        rd_chk("key_ack", IDX_KEY_FLAG, 8'hf0);
        rd_chk("in_svc", IDX_IN_SVC, 8'h01);
        chk("irq_same", 32'h0, {31'h0, irq_req_o});
        for (int l = 1; l < 4; l++) begin
            wr(IDX_PRIO_LO, l[0] ? 8'h3f : 8'h00);
            wr(IDX_PRIO_HI, l[1] ? 8'h3f : 8'h00);
            wait_cyc(2);
            chk("lvl", l, {30'h0, irq_lvl_o});
            chk("preempt", 32'h1, {31'h0, irq_req_o});
        end
        wr(IDX_KEY_FLAG, 8'h00);
        wr(IDX_PRIO_LO, 8'h00);
        wr(IDX_PRIO_HI, 8'h00);
        ret_pulse();
        wr(IDX_MAIN_EN, 8'h80);
        wr(IDX_TMR_EN, 8'h10);
        per_set <= 24'h71e000;
        @(posedge clk);
        per_set <= 24'h0;
        wait_cyc(2);
        chk("vec_t3", 32'd16, {27'h0, irq_vec_o});
        wr(IDX_TMR_EN, 8'h1e);
        wait_cyc(2);
        chk("vec_t0", 32'd13, {27'h0, irq_vec_o});
        wr(IDX_TMR_EN, 8'h00);
        wr(IDX_SYS_EN, 8'h10);
        wait_cyc(2);
        chk("vec_bit", 32'd22, {27'h0, irq_vec_o});
        chk("req_bit", 32'h1, {31'h0, irq_req_o});
        wr(IDX_SYS_EN, 8'h08);
        wait_cyc(2);
        chk("vec_wdog", 32'd21, {27'h0, irq_vec_o});
        wr(IDX_SYS_EN, 8'h1c);
        wait_cyc(2);
        chk("vec_watch", 32'd20, {27'h0, irq_vec_o});
        rd_chk("evt_all", IDX_EVT_STAT, 8'h0d);
        $display("test cpu done");
        stop_test();
    end

    initial begin
        repeat (6000) @(posedge clk);
        $display("BAD watchdog exp done got hang");
        err_total++;
        stop_test();
    end
endmodule : iep_ctrl_tb_top
